// >>> pkg/power_good_fault_monitor_regs.svh
// Register offsets, field positions, reset values and timing counts of the monitor.
// Assumes a 40 MHz system clock and a 12-bit APB byte address.
`ifndef POWER_GOOD_FAULT_MONITOR_REGS_SVH
`define POWER_GOOD_FAULT_MONITOR_REGS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PGM_CLK_MHZ 40
`define LIMIT_TIME_US 20
`define LIMIT_CYCLES (`LIMIT_TIME_US * `PGM_CLK_MHZ)
`define SHORT_TIME_MS 1
`define SHORT_CYCLES (`SHORT_TIME_MS * 1000 * `PGM_CLK_MHZ)
`define GATE_TIME_US 800
`define GATE_CYCLES (`GATE_TIME_US * `PGM_CLK_MHZ)

// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define OFF_CTRL 12'h000
`define OFF_FLAGS 12'h004
`define OFF_MASK 12'h008
`define OFF_STATUS 12'h00C
`define OFF_FAULT 12'h010

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define CTRL_MODE 0
`define CTRL_FHOLD 1
`define CTRL_WLEVEL 2
`define CTRL_TWPG 3
`define CTRL_REQ_LSB 4
`define CTRL_DIS_LSB 8
`define CTRL_PGSEL_LSB 12
`define CTRL_GPA 16
`define CTRL_GPB 17
`define FL_LIM_LSB 0
`define FL_SHORT_LSB 4
`define FL_TWARN 8
`define FL_TSD 9
`define FL_OVP 10
`define MK_LIM_LSB 0
`define MK_TWARN 8
`define ST_ON_LSB 0
`define ST_LIM_LSB 4
`define ST_TWARN 8
`define ST_TSD 9
`define ST_OVP 10
`define ST_PG 11
`define ST_SUM_LSB 12
`define FT_LSB 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PGSEL_RST 4'hF

`endif

// >>> pkg/pgm_pkg.sv
// Types shared by the power-good and fault monitor and its persistence timers.
// Assumes the register header is included by the files that need numbers.
package pgm_pkg;

   typedef enum logic {PG_GATED, PG_CONTINUOUS} pg_mode_type;

   typedef struct packed {
      logic [15:0] count;
      logic hit;
   } persist_state_type;

   typedef struct packed {
      logic [20:0] s1;
      logic [20:0] s2;
      pg_mode_type pg_mode_select;
      logic fault_holds_pg;
      logic warning_level_select;
      logic twarn_to_pg;
      logic [3:0] rail_request;
      logic [3:0] discharge_enable;
      logic [3:0] pg_select;
      logic general_a;
      logic general_b;
      logic [3:0] limit_flag;
      logic [3:0] limit_mask;
      logic [3:0] short_flag;
      logic thermal_warning_flag;
      logic thermal_warning_mask;
      logic thermal_shutdown_flag;
      logic overvoltage_flag;
      logic [3:0] regulator_fault_latch;
      logic [3:0] on_status;
      logic warn_prev;
      logic otp_done;
      logic power_good;
      logic irq;
      logic gpo_a;
      logic gpo_b;
      logic [15:0] gate_count;
      logic [31:0] rdata;
   } monitor_state_type;

endpackage

// >>> hw/persist_timer.sv
// Persistence timer: pulses once when its input has stayed high for LIMIT cycles.
// Assumes a synchronised input on the system clock.
`timescale 1ns/10ps
module persist_timer import pgm_pkg::*; #(
   parameter int LIMIT = 800
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // Level to watch
   input wire logic i_level,
   // Pulse when the level has persisted
   output logic o_hit
);

   persist_state_type st;
   persist_state_type next_st;

   always_comb begin
      next_st = st;
      next_st.hit = 1'b0;
      if (!i_level) begin
         next_st.count = 16'h0000;
      end else if (st.count < 16'(LIMIT)) begin
         next_st.count = st.count + 16'h0001;
         next_st.hit = (st.count == 16'(LIMIT - 1));
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_hit = st.hit;

endmodule // persist_timer

// >>> hw/power_good_fault_monitor.sv
// Power-good output, fault latches, warning flags and protective disables.
// Assumes comparator levels arrive asynchronously and software uses APB.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "power_good_fault_monitor_regs.svh"

module power_good_fault_monitor import pgm_pkg::*; #(
   parameter int SHORT_CYCLES = `SHORT_CYCLES,
   parameter int GATE_CYCLES = `GATE_CYCLES
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Comparator levels, index 0..1 switchers, 2..3 linears
   input wire logic [3:0] i_rail_in_range,
   input wire logic [3:0] i_rail_below_short,
   input wire logic [3:0] i_rail_ramping,
   input wire logic [3:0] i_rail_current_limit,
   input wire logic i_temp_warn_high,
   input wire logic i_temp_warn_low,
   input wire logic i_temp_shutdown,
   input wire logic i_input_overvoltage,
   input wire logic i_otp_loaded,
   // Regulator control
   output logic [3:0] o_regulator_on,
   output logic [3:0] o_switch_hiz,
   output logic [3:0] o_discharge_on,
   output logic o_standby,
   // Pins
   output logic o_power_good_out,
   output logic o_irq_line_n,
   output logic o_general_output_a,
   output logic o_general_output_b
);

   // --------------------------------------------------------------------------
   // Declarations
   // --------------------------------------------------------------------------
   monitor_state_type st;
   monitor_state_type next_st;
   logic [20:0] raw;
   logic [3:0] in_range;
   logic [3:0] below_short;
   logic [3:0] ramping;
   logic [3:0] limit_status;
   logic thermal_warning_status;
   logic thermal_shutdown_status;
   logic overvoltage_status;
   logic otp_in;
   logic [3:0] limit_hit;
   logic [3:0] short_hit;
   logic [3:0] short_level;
   logic wr_en;
   logic rd_setup;
   logic hit_ctrl;
   logic hit_flags;
   logic hit_mask;
   logic hit_fault;
   logic mapped;
   logic [10:0] flag_clr;
   logic [3:0] fault_clr;
   logic global_block;
   logic [3:0] block;
   logic [3:0] on_next;
   logic [3:0] on_rise;
   logic warn_level;
   logic [3:0] rail_ok;
   logic [3:0] rail_bad;
   logic sources_ok;
   logic fault_hold;
   logic gate_open;
   logic gate_reload;
   logic [3:0] fault_set;
   logic irq_any;
   logic [31:0] read_mux;

   // --------------------------------------------------------------------------
   // Input synchronisers
   // --------------------------------------------------------------------------
   assign raw = {i_otp_loaded, i_input_overvoltage, i_temp_shutdown, i_temp_warn_low,
                 i_temp_warn_high, i_rail_current_limit, i_rail_ramping,
                 i_rail_below_short, i_rail_in_range};
   assign in_range = st.s2[3:0];
   assign below_short = st.s2[7:4];
   assign ramping = st.s2[11:8];
   assign limit_status = st.s2[15:12];
   assign warn_level = st.warning_level_select ? st.s2[16] : st.s2[17];
   assign thermal_warning_status = warn_level;
   assign thermal_shutdown_status = st.s2[18];
   assign overvoltage_status = st.s2[19] & st.otp_done;
   assign otp_in = st.s2[20];

   // --------------------------------------------------------------------------
   // Persistence timers
   // --------------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_rail
         persist_timer #(
            .LIMIT(`LIMIT_CYCLES)
         ) u_limit (
            .i_clk_sys(i_clk_sys),
            .i_nrst(i_nrst),
            .i_level(limit_status[gi] & st.on_status[gi]),
            .o_hit(limit_hit[gi])
         );
         persist_timer #(
            .LIMIT(SHORT_CYCLES)
         ) u_short (
            .i_clk_sys(i_clk_sys),
            .i_nrst(i_nrst),
            .i_level(short_level[gi]),
            .o_hit(short_hit[gi])
         );
      end
   endgenerate
   assign short_level = below_short & st.on_status;

   // --------------------------------------------------------------------------
   // Bus decode
   // --------------------------------------------------------------------------
   assign wr_en = i_psel & i_penable & i_pwrite;
   assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
   assign hit_ctrl = wr_en & (i_paddr == `OFF_CTRL);
   assign hit_flags = wr_en & (i_paddr == `OFF_FLAGS);
   assign hit_mask = wr_en & (i_paddr == `OFF_MASK);
   assign hit_fault = wr_en & (i_paddr == `OFF_FAULT);
   assign mapped = (i_paddr == `OFF_CTRL) | (i_paddr == `OFF_FLAGS) |
                   (i_paddr == `OFF_MASK) | (i_paddr == `OFF_STATUS) |
                   (i_paddr == `OFF_FAULT);
   assign flag_clr = hit_flags ? i_pwdata[10:0] : 11'h000;
   assign fault_clr = hit_fault ? i_pwdata[`FT_LSB +: 4] : 4'h0;

   always_comb begin
      case (i_paddr)
         `OFF_CTRL: begin
            read_mux = {14'h0000, st.general_b, st.general_a, st.pg_select,
                        st.discharge_enable, st.rail_request, st.twarn_to_pg,
                        st.warning_level_select, st.fault_holds_pg, st.pg_mode_select};
         end
         `OFF_FLAGS: begin
            read_mux = {21'h000000, st.overvoltage_flag, st.thermal_shutdown_flag,
                        st.thermal_warning_flag, st.short_flag, st.limit_flag};
         end
         `OFF_MASK: begin
            read_mux = {23'h000000, st.thermal_warning_mask, 4'h0, st.limit_mask};
         end
         `OFF_STATUS: begin
            read_mux = {16'h0000, st.short_flag, st.power_good, overvoltage_status,
                        thermal_shutdown_status, thermal_warning_status, limit_status,
                        st.on_status};
         end
         `OFF_FAULT: begin
            read_mux = {28'h0000000, st.regulator_fault_latch};
         end
         default: begin
            read_mux = 32'h00000000;
         end
      endcase
   end

   // --------------------------------------------------------------------------
   // Protection and power-good terms
   // --------------------------------------------------------------------------
   // Overvoltage blocks all rails.
   assign global_block = overvoltage_status | st.overvoltage_flag |
                         thermal_shutdown_status | st.thermal_shutdown_flag | ~st.otp_done;
   assign block = {4{global_block}} | st.short_flag | short_hit;
   assign on_next = st.rail_request & ~block;
   assign on_rise = on_next & ~st.on_status;
   assign rail_ok = ~st.on_status | ~st.pg_select | (in_range & ~ramping);
   assign rail_bad = st.on_status & st.pg_select & ~in_range & ~ramping;
   assign sources_ok = (&rail_ok) & ~(st.twarn_to_pg & thermal_warning_status) &
                       ~st.overvoltage_flag & ~st.thermal_shutdown_flag;
   assign fault_hold = st.fault_holds_pg & (|st.regulator_fault_latch);
   assign gate_open = (st.gate_count == 16'h0000);
   assign gate_reload = (|on_rise) | (|(ramping & st.on_status));
   assign fault_set = rail_bad & {4{(st.pg_mode_select == PG_CONTINUOUS) | gate_open}};
   assign irq_any = (|(st.limit_flag & ~st.limit_mask)) | (|st.short_flag) |
                    (st.thermal_warning_flag & ~st.thermal_warning_mask) |
                    st.thermal_shutdown_flag | st.overvoltage_flag;

   // --------------------------------------------------------------------------
   // Next state
   // --------------------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.s1 = raw;
      next_st.s2 = st.s1;
      next_st.otp_done = st.otp_done | otp_in;
      if (hit_ctrl) begin
         next_st.pg_mode_select = pg_mode_type'(i_pwdata[`CTRL_MODE]);
         next_st.fault_holds_pg = i_pwdata[`CTRL_FHOLD];
         next_st.warning_level_select = i_pwdata[`CTRL_WLEVEL];
         next_st.twarn_to_pg = i_pwdata[`CTRL_TWPG];
         next_st.rail_request = i_pwdata[`CTRL_REQ_LSB +: 4];
         next_st.discharge_enable = i_pwdata[`CTRL_DIS_LSB +: 4];
         next_st.pg_select = i_pwdata[`CTRL_PGSEL_LSB +: 4];
         next_st.general_a = i_pwdata[`CTRL_GPA];
         next_st.general_b = i_pwdata[`CTRL_GPB];
      end
      if (hit_mask) begin
         next_st.limit_mask = i_pwdata[`MK_LIM_LSB +: 4];
         next_st.thermal_warning_mask = i_pwdata[`MK_TWARN];
      end
      next_st.limit_flag = (st.limit_flag & ~flag_clr[`FL_LIM_LSB +: 4]) | limit_hit;
      next_st.short_flag = (st.short_flag & ~flag_clr[`FL_SHORT_LSB +: 4]) | short_hit;
      next_st.thermal_warning_flag = (st.thermal_warning_flag & ~flag_clr[`FL_TWARN]) |
                                     (warn_level & ~st.warn_prev);
      next_st.warn_prev = warn_level;
      next_st.thermal_shutdown_flag = (st.thermal_shutdown_flag & ~flag_clr[`FL_TSD]) |
                                      thermal_shutdown_status;
      next_st.overvoltage_flag = (st.overvoltage_flag & ~flag_clr[`FL_OVP]) |
                                 overvoltage_status;
      next_st.regulator_fault_latch = (st.regulator_fault_latch & ~fault_clr) | fault_set;
      next_st.on_status = on_next;
      next_st.gpo_a = st.general_a & ~global_block;
      next_st.gpo_b = st.general_b & ~global_block;
      // Window restarts on enable or ramp.
      if (gate_reload) begin
         next_st.gate_count = 16'(GATE_CYCLES);
      end else if (!gate_open) begin
         next_st.gate_count = st.gate_count - 16'h0001;
      end
      if (!st.otp_done) begin
         next_st.power_good = otp_in;
      end else if (st.pg_mode_select == PG_CONTINUOUS) begin
         next_st.power_good = ~(|on_rise) & sources_ok & ~fault_hold;
      end else if (gate_open & ~gate_reload) begin
         next_st.power_good = sources_ok & ~(|st.regulator_fault_latch);
      end
      next_st.irq = irq_any;
      if (rd_setup) begin
         next_st.rdata = read_mux;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         st <= '0;
         st.pg_select <= `PGSEL_RST;
      end else begin
         st <= next_st;
      end
   end

   // --------------------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------------------
   assign o_prdata = st.rdata;
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel & i_penable & ~mapped;
   assign o_regulator_on = st.on_status;
   assign o_switch_hiz = ~st.on_status;
   assign o_discharge_on = ~st.on_status & st.discharge_enable;
   // Standby when no rail is on.
   assign o_standby = ~(|st.on_status);
   assign o_power_good_out = st.power_good;
   assign o_irq_line_n = ~st.irq;
   assign o_general_output_a = st.gpo_a;
   assign o_general_output_b = st.gpo_b;

endmodule // power_good_fault_monitor

// >>> test/pgm_host_model.sv
// Host processor model: APB master and interrupt line watcher.
// Assumes zero or more wait states; every wait is bounded.
`timescale 1ns/10ps
module pgm_host_model (
   // Clock
   input wire logic i_clk_sys,
   // APB answer and interrupt
   input wire logic i_pready,
   input wire logic [31:0] i_prdata,
   input wire logic i_pslverr,
   input wire logic i_irq_line_n,
   // APB request
   output logic o_psel,
   output logic o_penable,
   output logic o_pwrite,
   output logic [11:0] o_paddr,
   output logic [31:0] o_pwdata
);
   int irq_events = 0;
   logic irq_prev = 1'b1;
   initial begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 12'h000;
      o_pwdata = 32'h0;
   end
   always @(posedge i_clk_sys) begin
      if (irq_prev && !i_irq_line_n) irq_events++;
      irq_prev <= i_irq_line_n;
   end
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e, output bit to);
      int n;
      @(posedge i_clk_sys);
      o_psel <= 1'b1;
      o_pwrite <= wr;
      o_paddr <= a;
      o_pwdata <= d;
      @(posedge i_clk_sys);
      o_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (i_pready !== 1'b1 && n < 16);
      to = (n >= 16);
      q = i_prdata;
      e = i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      o_paddr <= ~a;
      o_pwdata <= ~d;
   endtask
endmodule // pgm_host_model

// >>> test/power_good_fault_monitor_properties.sv
// Port checker for the power-good and fault monitor.
// Assumes it is bound into the monitor and sees only its ports.
`timescale 1ns/10ps
module pgm_checker #(
   parameter int SHORT_CYCLES = 50,
   parameter int GATE_CYCLES = 40
) (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic [3:0] i_rail_below_short,
   input wire logic i_temp_shutdown,
   input wire logic i_input_overvoltage,
   input wire logic i_otp_loaded,
   input wire logic [3:0] o_regulator_on,
   input wire logic [3:0] o_switch_hiz,
   input wire logic [3:0] o_discharge_on,
   input wire logic o_standby,
   input wire logic o_power_good_out,
   input wire logic o_irq_line_n,
   input wire logic o_general_output_a,
   input wire logic o_general_output_b
);
   localparam int PG_LIM = GATE_CYCLES + 8;
   int short_cnt;
   logic ov_on;
   assign ov_on = i_input_overvoltage && i_otp_loaded;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   // Count cycles of a short on rail 0.
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst)
         short_cnt <= 0;
      else if (o_regulator_on[0] && i_rail_below_short[0])
         short_cnt <= short_cnt + 1;
      else
         short_cnt <= 0;
   end
   switch_off_a: assert property (o_switch_hiz == ~o_regulator_on)
      else $error("switch state differs from regulator state");
   discharge_off_a: assert property ((o_discharge_on & o_regulator_on) == 4'h0)
      else $error("discharge on a running regulator");
   standby_state_a: assert property (o_standby == (o_regulator_on == 4'h0))
      else $error("standby differs from regulator state");
   ov_disable_a: assert property (ov_on [*6] |=> o_regulator_on == 4'h0)
      else $error("regulator on during overvoltage");
   ov_gpo_low_a: assert property (ov_on [*6] |=> !o_general_output_a && !o_general_output_b)
      else $error("general output high during overvoltage");
   ov_irq_a: assert property (ov_on [*6] |=> !o_irq_line_n)
      else $error("no interrupt on overvoltage");
   ov_pg_low_a: assert property (ov_on [*6] |-> ##[1:PG_LIM] !o_power_good_out)
      else $error("power good stays high on overvoltage");
   tsd_standby_a: assert property (i_temp_shutdown [*6] |=> o_standby)
      else $error("no standby on thermal shutdown");
   short_bound_a: assert property (short_cnt <= SHORT_CYCLES + 6)
      else $error("shorted regulator stays on");
   short_irq_a: assert property ($fell(o_regulator_on[0]) && short_cnt >= SHORT_CYCLES
         |-> ##[1:2] !o_irq_line_n)
      else $error("no interrupt on short");
   cover property ($fell(o_regulator_on[0]) && short_cnt >= SHORT_CYCLES);
   cover property (ov_on [*6]);
   cover property ($rose(o_power_good_out));
endmodule // pgm_checker

bind power_good_fault_monitor pgm_checker #(
   .SHORT_CYCLES(SHORT_CYCLES),
   .GATE_CYCLES(GATE_CYCLES)
) chk_inst (
   .i_clk_sys, .i_nrst, .i_rail_below_short, .i_temp_shutdown, .i_input_overvoltage,
   .i_otp_loaded, .o_regulator_on, .o_switch_hiz, .o_discharge_on, .o_standby,
   .o_power_good_out, .o_irq_line_n, .o_general_output_a, .o_general_output_b
);

// >>> test/tb_power_good_fault_monitor.sv
// Self-checking bench for the power-good and fault monitor.
// Assumes shortened counts: short 50 cycles, gate window 40 cycles.
`timescale 1ns/10ps
module tb_power_good_fault_monitor;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel, pen, pwr, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] rng = 4'hF, bsh = 4'h0, ramp = 4'h0, lim = 4'h0, ron, hiz, dis;
   logic twh = 1'b0, twl = 1'b0, tsd = 1'b0, ov = 1'b0, otp = 1'b0;
   logic stby, pg, irqn, ga, gb, e;
   int mismatches = 0, check_count = 0, i, ctrl_m;
   bit lo;
   logic [15:0] seed = 16'h1B75;
   always #12.5 clk = ~clk;
   power_good_fault_monitor #(.SHORT_CYCLES(50), .GATE_CYCLES(40)) DUT (
      .i_clk_sys(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_rail_in_range(rng), .i_rail_below_short(bsh),
      .i_rail_ramping(ramp), .i_rail_current_limit(lim), .i_temp_warn_high(twh),
      .i_temp_warn_low(twl), .i_temp_shutdown(tsd), .i_input_overvoltage(ov),
      .i_otp_loaded(otp), .o_regulator_on(ron), .o_switch_hiz(hiz), .o_discharge_on(dis),
      .o_standby(stby), .o_power_good_out(pg), .o_irq_line_n(irqn),
      .o_general_output_a(ga), .o_general_output_b(gb));
   pgm_host_model host (.i_clk_sys(clk), .i_pready(pready), .i_prdata(prdata),
      .i_pslverr(pslverr), .i_irq_line_n(irqn), .o_psel(psel), .o_penable(pen),
      .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_nib(input logic [3:0] got, input logic [3:0] exp);
      chk_word({28'h0, got}, {28'h0, exp});
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      bit to;
      host.xfer(w, a, d, q, e, to);
      if (to) begin
         mismatches++;
         finish_test();
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk_word(q, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic watch(input int n);
      lo = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (pg !== 1'b1) lo = 1;
      end
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      finish_test();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      rdc(12'h000, 32'h0000F000);
      rdc(12'h004, 32'h0);
      rdc(12'h010, 32'h0);
      bus(1'b0, 12'h020, 32'h0);
      chk_bit(e, 1'b1);
      for (i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         bus(1'b1, 12'h008, {16'h0, seed});
         rdc(12'h008, {16'h0, seed} & 32'h10F);
      end
      bus(1'b1, 12'h01C, {seed, seed});
      chk_bit(e, 1'b1);
      rdc(12'h000, 32'h0000F000);
      bus(1'b1, 12'h008, 32'h0);
      otp <= 1'b1;
      settle(8);
      chk_bit(pg, 1'b1);
      $display("test registers done");
      ctrl_m = 32'h3FFF1;
      bus(1'b1, 12'h000, ctrl_m);
      watch(6);
      chk_bit(lo, 1'b1);
      settle(4);
      chk_nib(ron, 4'hF);
      chk_bit(pg, 1'b1);
      chk_bit(ga & gb, 1'b1);
      rng <= 4'hD;
      settle(6);
      chk_bit(pg, 1'b0);
      rng <= 4'hF;
      settle(6);
      chk_bit(pg, 1'b1);
      rdc(12'h010, 32'h2);
      bus(1'b1, 12'h010, 32'h2);
      rdc(12'h010, 32'h0);
      ctrl_m = ctrl_m | 32'h6;
      bus(1'b1, 12'h000, ctrl_m);
      rng <= 4'hD;
      settle(6);
      rng <= 4'hF;
      settle(6);
      chk_bit(pg, 1'b0);
      bus(1'b1, 12'h010, 32'h2);
      settle(4);
      chk_bit(pg, 1'b1);
      ramp <= 4'h4;
      settle(6);
      chk_bit(pg, 1'b0);
      ramp <= 4'h0;
      settle(6);
      chk_bit(pg, 1'b1);
      $display("test continuous done");
      lim <= 4'h1;
      settle(810);
      rdc(12'h00C, 32'h81F);
      rdc(12'h004, 32'h1);
      chk_bit(irqn, 1'b0);
      lim <= 4'h0;
      bus(1'b1, 12'h004, 32'h1);
      settle(4);
      chk_bit(irqn, 1'b1);
      bus(1'b1, 12'h008, 32'h8);
      lim <= 4'h8;
      settle(810);
      rdc(12'h004, 32'h8);
      chk_bit(irqn, 1'b1);
      lim <= 4'h0;
      bus(1'b1, 12'h004, 32'h8);
      bus(1'b1, 12'h008, 32'h0);
      twl <= 1'b1;
      settle(6);
      rdc(12'h004, 32'h0);
      twh <= 1'b1;
      settle(6);
      rdc(12'h004, 32'h100);
      chk_bit(irqn, 1'b0);
      twh <= 1'b0;
      twl <= 1'b0;
      settle(6);
      bus(1'b1, 12'h004, 32'h100);
      $display("test warnings done");
      bsh <= 4'h1;
      settle(60);
      chk_nib(ron, 4'hE);
      chk_nib(dis, 4'h1);
      chk_nib(hiz, 4'h1);
      rdc(12'h00C, 32'h180E);
      chk_bit(irqn, 1'b0);
      bsh <= 4'h0;
      bus(1'b1, 12'h004, 32'h10);
      settle(3);
      chk_nib(ron, 4'hF);
      $display("test short done");
      ov <= 1'b1;
      settle(8);
      chk_nib(ron, 4'h0);
      chk_bit(ga | gb, 1'b0);
      bus(1'b1, 12'h004, 32'h400);
      rdc(12'h004, 32'h400);
      settle(50);
      chk_bit(pg, 1'b0);
      ov <= 1'b0;
      settle(6);
      chk_nib(ron, 4'h0);
      bus(1'b1, 12'h004, 32'h400);
      settle(4);
      chk_nib(ron, 4'hF);
      tsd <= 1'b1;
      settle(8);
      chk_bit(stby, 1'b1);
      chk_bit(irqn, 1'b0);
      tsd <= 1'b0;
      settle(6);
      bus(1'b1, 12'h004, 32'h200);
      settle(4);
      chk_nib(ron, 4'hF);
      $display("test protection done");
      ctrl_m = ctrl_m & 32'hFFFFFFFC;
      bus(1'b1, 12'h000, ctrl_m);
      settle(60);
      chk_bit(pg, 1'b1);
      rng <= 4'hD;
      ramp <= 4'h2;
      settle(10);
      ramp <= 4'h0;
      watch(20);
      chk_bit(lo, 1'b0);
      settle(40);
      chk_bit(pg, 1'b0);
      rdc(12'h010, 32'h2);
      rng <= 4'hF;
      settle(10);
      chk_bit(pg, 1'b0);
      bus(1'b1, 12'h010, 32'h2);
      settle(6);
      chk_bit(pg, 1'b1);
      chk_word(host.irq_events, 32'h5);
      $display("test gated done");
      finish_test();
   end
endmodule // tb_power_good_fault_monitor
